// ===== src/adc_seq_params.svh
// Constants for the conversion sequencer: register map, fields, timing.
// Assumes inclusion by bare name from the design files under src/.
//
// Notes on behaviour
// [RULE1] Enabled converter repeats cycles of one-to-eight conversions.
// [RULE2] Slots visited in fixed ascending order.
// [RULE3] Enabled slot converts; disabled slot skipped immediately.
// [RULE4] Each result lands in its own slot register.
// [RULE5] Three-bit mux field picks one of seven sources.
// [RULE6] Control byte: enable, resolution, span, mux fields.
// [RULE7] Resolution spans nine to sixteen bits including sign.
// [RULE8] Conversion lasts 30.52 us times two-to-n.
// [RULE9] Span bit: zero gives 170 mV, one 340 mV.
// [RULE10] Results are sign/magnitude, sign in bit 15.
// [RULE11] Code 111 is sixteen bits, 001 ten bits.
// [RULE12] Mux code 000 routes sense input to converter.
// [RULE13] Accumulator feed comes only from slot zero result.
// [RULE14] Offset source shorts converter input to ground.
// [RULE15] Host programs voltage slots with matching sources.
// [RULE16] Host uses 170 mV for current, 340 otherwise.
// [RULE17] Host reaches all registers over two-wire bus.
// [RULE18] Resolution codes map linearly, one bit per step.
// [RULE19] Wrap to slot zero; all disabled means idle.
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// =============================================================
// Register map (two-wire pointer values)
`define CTRL_BASE 8'h00
`define CTRL_LAST 8'h07
`define RESULT_BASE 8'h10
`define RESULT_LAST 8'h1f
`define CTRL_RESET 8'h00
`define RESULT_RESET 16'h0000

// =============================================================
// Control byte fields
`define EN_BIT 7
`define RES_MSB 6
`define RES_LSB 4
`define REF_BIT 3
`define SEL_MSB 2
`define SEL_LSB 0

// =============================================================
// Slots and timing
`define NUM_SLOTS 8
`define CURRENT_SLOT 3'h0
`define MIN_RES_BITS 9
`define CLK_PERIOD_NS 10.0
`define CONV_UNIT_US 30.52
`define CONV_UNIT_CYCLES ((`CONV_UNIT_US * 1000.0) / `CLK_PERIOD_NS)
// Arbitrary neutral bus address
`define DEVICE_ADDR 7'h2a

`endif

// ===== src/adc_seq_pkg.sv
// Types shared by the conversion sequencer files.
// Assumes no other package is imported alongside it.
package adc_seq_pkg;

    // =========================================================
    // Input mux sources
    typedef enum logic [2:0] {
        SRC_SENSE = 3'b000,
        SRC_INNER_TEMP = 3'b001,
        SRC_THERMISTOR = 3'b010,
        SRC_PACK = 3'b011,
        SRC_UPPER_CELL = 3'b100,
        SRC_LOWER_CELL = 3'b101,
        SRC_OFFSET = 3'b110,
        SRC_UNUSED = 3'b111
    } mux_src_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_SELECT = 2'b01,
        SEQ_CONVERT = 2'b10,
        SEQ_STORE = 2'b11
    } seq_state_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_ACK_ADDR = 3'b010,
        BUS_WRITE = 3'b011,
        BUS_ACK_WRITE = 3'b100,
        BUS_READ = 3'b101,
        BUS_ACK_READ = 3'b110
    } bus_state_t;

    typedef struct packed {
        logic enable;
        logic [2:0] res_code;
        logic ref_span;
        mux_src_t source;
    } slot_ctrl_t;

    typedef struct packed {
        logic convert;
        logic input_short;
        logic ref_span;
        logic [2:0] res_code;
        mux_src_t source;
    } front_end_t;

endpackage

// ===== src/conv_timer.sv
// Conversion duration timer: one unit of time is counted in core
// clocks, and the conversion lasts two-to-n units.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module conv_timer #(
    parameter int unsigned UNIT_CYCLES = 3052
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic abort,
    input wire logic [2:0] res_code,
    output logic busy,
    output logic done
);
    import adc_seq_pkg::*;

    logic [31:0] unit_cnt;
    logic [16:0] unit_total;
    logic [16:0] units_done;

    // =========================================================
    // Prescaler and unit counter
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            unit_cnt <= 32'h0;
            units_done <= 17'h0;
            unit_total <= 17'h0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
            end else if (start) begin
                busy <= 1'b1;
                unit_cnt <= 32'h0;
                units_done <= 17'h0;
                // Two to the n units, n = 9 + code  (see [RULE8] [RULE18])
                unit_total <= 17'h1 << (5'(`MIN_RES_BITS) + 5'(res_code));
            end else if (busy) begin
                if (unit_cnt == UNIT_CYCLES - 1) begin
                    unit_cnt <= 32'h0;
                    if (units_done + 17'h1 == unit_total) begin
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                    units_done <= units_done + 17'h1;
                end else begin
                    unit_cnt <= unit_cnt + 32'h1;
                end
            end
        end
    end

endmodule

// ===== src/adc_conversion_sequencer.sv
// Conversion sequencer with two-wire register access.
// Assumes scl/sda inputs are already synchronous to core_clk and
// that the modulator presents its magnitude when convert falls.
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module adc_conversion_sequencer #(
    parameter int unsigned UNIT_CYCLES = int'(`CONV_UNIT_CYCLES)
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic adc_enable,
    input wire logic mod_sign,
    input wire logic [14:0] mod_magnitude,
    output adc_seq_pkg::front_end_t front_end,
    output logic [2:0] active_slot,
    output logic [15:0] current_result,
    output logic current_result_strobe
);
    import adc_seq_pkg::*;

    // =========================================================
    // Storage
    slot_ctrl_t slot_ctrl [`NUM_SLOTS];
    logic [15:0] slot_result [`NUM_SLOTS];

    seq_state_t seq_state;
    logic [2:0] slot;
    slot_ctrl_t active;
    logic any_enabled;
    logic timer_start;
    logic timer_busy;
    logic timer_done;
    logic abort;

    bus_state_t bus_state;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic ptr_phase;
    logic rw;
    logic master_nack;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_byte;

    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;

    // =========================================================
    // Register read decode
    function automatic logic [7:0] read_byte(input logic [7:0] addr);
        logic [7:0] data;
        logic [15:0] res;
        data = 8'h00;
        res = slot_result[addr[3:1]];
        if (addr <= `CTRL_LAST) begin
            data = slot_ctrl[addr[2:0]];
        end else if (addr >= `RESULT_BASE && addr <= `RESULT_LAST) begin
            data = addr[0] ? res[15:8] : res[7:0];
        end
        return data;
    endfunction

    // Magnitude kept to the selected resolution
    function automatic logic [15:0] pack_result(input logic [2:0] code,
            input logic sign, input logic [14:0] mag);
        logic [14:0] mask;
        mask = 15'h7fff >> (3'h7 - code);  // see [RULE7] [RULE11]
        return {sign, mag & mask};  // see [RULE10]
    endfunction

    // =========================================================
    // Bus line edges and conditions
    assign start_cond = scl_q && scl_in && sda_q && !sda_in;
    assign stop_cond = scl_q && scl_in && !sda_q && sda_in;
    assign scl_rise = !scl_q && scl_in;
    assign scl_fall = scl_q && !scl_in;
    assign sda_out = 1'b0;
    always_comb rd_byte = read_byte(ptr);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // =========================================================
    // Two-wire slave engine  (see [RULE17])
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_state <= BUS_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            ptr_phase <= 1'b0;
            rw <= 1'b0;
            master_nack <= 1'b0;
            sda_oe <= 1'b0;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            wr_en <= 1'b0;
            if (start_cond) begin
                bus_state <= BUS_ADDR;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_cond) begin
                bus_state <= BUS_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (bus_state)
                    BUS_ADDR, BUS_WRITE: begin
                        shift <= {shift[6:0], sda_in};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    BUS_READ: begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    BUS_ACK_READ: begin
                        master_nack <= sda_in;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (bus_state)
                    BUS_ADDR: begin
                        if (bit_cnt == 4'h8) begin
                            if (shift[7:1] == `DEVICE_ADDR) begin
                                bus_state <= BUS_ACK_ADDR;
                                rw <= shift[0];
                                sda_oe <= 1'b1;
                            end else begin
                                bus_state <= BUS_IDLE;
                            end
                        end
                    end
                    BUS_ACK_ADDR: begin
                        bit_cnt <= 4'h0;
                        if (rw) begin
                            tx <= rd_byte;
                            sda_oe <= !rd_byte[7];
                            ptr <= ptr + 8'h1;
                            bus_state <= BUS_READ;
                        end else begin
                            sda_oe <= 1'b0;
                            ptr_phase <= 1'b1;
                            bus_state <= BUS_WRITE;
                        end
                    end
                    BUS_WRITE: begin
                        if (bit_cnt == 4'h8) begin
                            sda_oe <= 1'b1;
                            bus_state <= BUS_ACK_WRITE;
                            if (ptr_phase) begin
                                ptr <= shift;
                                ptr_phase <= 1'b0;
                            end else begin
                                wr_en <= 1'b1;
                                wr_addr <= ptr;
                                wr_data <= shift;
                                ptr <= ptr + 8'h1;
                            end
                        end
                    end
                    BUS_ACK_WRITE: begin
                        sda_oe <= 1'b0;
                        bit_cnt <= 4'h0;
                        bus_state <= BUS_WRITE;
                    end
                    BUS_READ: begin
                        if (bit_cnt == 4'h8) begin
                            sda_oe <= 1'b0;
                            bus_state <= BUS_ACK_READ;
                        end else begin
                            sda_oe <= !tx[3'(4'h7 - bit_cnt)];
                        end
                    end
                    BUS_ACK_READ: begin
                        if (master_nack) begin
                            bus_state <= BUS_IDLE;
                        end else begin
                            tx <= rd_byte;
                            sda_oe <= !rd_byte[7];
                            ptr <= ptr + 8'h1;
                            bit_cnt <= 4'h0;
                            bus_state <= BUS_READ;
                        end
                    end
                    default: begin
                        bus_state <= BUS_IDLE;
                    end
                endcase
            end
        end
    end

    // =========================================================
    // Slot control registers  (see [RULE6])
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < `NUM_SLOTS; i++) begin
                slot_ctrl[i] <= `CTRL_RESET;
            end
        end else if (wr_en && wr_addr <= `CTRL_LAST) begin
            slot_ctrl[wr_addr[2:0]] <= wr_data;
        end
    end

    // =========================================================
    // Sequencer
    always_comb begin
        any_enabled = 1'b0;
        for (int i = 0; i < `NUM_SLOTS; i++) begin
            any_enabled = any_enabled | slot_ctrl[i].enable;
        end
    end

    assign timer_start = (seq_state == SEQ_SELECT) && adc_enable &&
        slot_ctrl[slot].enable;
    assign abort = !adc_enable && (seq_state == SEQ_CONVERT);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            seq_state <= SEQ_IDLE;
            slot <= 3'h0;
            active <= `CTRL_RESET;
        end else begin
            case (seq_state)
                SEQ_IDLE: begin
                    slot <= 3'h0;
                    // Nothing runs with every slot off  (see [RULE19])
                    if (adc_enable && any_enabled) begin
                        seq_state <= SEQ_SELECT;  // see [RULE1]
                    end
                end
                SEQ_SELECT: begin
                    if (!adc_enable || !any_enabled) begin
                        seq_state <= SEQ_IDLE;
                    end else if (slot_ctrl[slot].enable) begin
                        active <= slot_ctrl[slot];  // see [RULE3]
                        seq_state <= SEQ_CONVERT;
                    end else begin
                        // Skip disabled slot, wrap 7 to 0  (see [RULE2])
                        slot <= slot + 3'h1;  // see [RULE3] [RULE19]
                    end
                end
                SEQ_CONVERT: begin
                    if (abort) begin
                        seq_state <= SEQ_IDLE;
                    end else if (timer_done) begin
                        seq_state <= SEQ_STORE;  // see [RULE8]
                    end
                end
                SEQ_STORE: begin
                    slot <= slot + 3'h1;  // see [RULE2] [RULE19]
                    seq_state <= SEQ_SELECT;
                end
                default: begin
                    seq_state <= SEQ_IDLE;
                end
            endcase
        end
    end

    conv_timer #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_timer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(timer_start),
        .abort(abort),
        .res_code(slot_ctrl[slot].res_code),
        .busy(timer_busy),
        .done(timer_done)
    );

    // =========================================================
    // Result registers, one per slot
    genvar g;
    generate
        for (g = 0; g < `NUM_SLOTS; g++) begin : g_result
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    slot_result[g] <= `RESULT_RESET;
                end else if (seq_state == SEQ_STORE && slot == 3'(g)) begin
                    slot_result[g] <= pack_result(active.res_code,
                        mod_sign, mod_magnitude);  // see [RULE4]
                end
            end
        end
    endgenerate

    // =========================================================
    // Accumulator feed from slot zero only
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            current_result <= `RESULT_RESET;
            current_result_strobe <= 1'b0;
        end else begin
            current_result_strobe <= 1'b0;
            if (seq_state == SEQ_STORE && slot == `CURRENT_SLOT) begin
                current_result <= pack_result(active.res_code,
                    mod_sign, mod_magnitude);  // see [RULE13]
                current_result_strobe <= 1'b1;  // see [RULE13]
            end
        end
    end

    // =========================================================
    // Front end controls
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            front_end <= '0;
            active_slot <= 3'h0;
        end else begin
            active_slot <= slot;
            front_end.convert <= timer_start ||
                (timer_busy && !timer_done && !abort);
            front_end.source <= active.source;  // see [RULE5] [RULE12]
            front_end.ref_span <= active.ref_span;  // see [RULE9]
            front_end.res_code <= active.res_code;  // see [RULE7]
            // Input shorted for the offset source  (see [RULE14])
            front_end.input_short <= (active.source == SRC_OFFSET);
            if (timer_start) begin
                front_end.source <= slot_ctrl[slot].source;
                front_end.ref_span <= slot_ctrl[slot].ref_span;
                front_end.res_code <= slot_ctrl[slot].res_code;
                front_end.input_short <=
                    (slot_ctrl[slot].source == SRC_OFFSET);
            end
        end
    end

endmodule

// ===== sim/adc_seq_chk.sv
// Port-level assertions for the conversion sequencer.
// Assumes it is bound onto adc_conversion_sequencer below.
`timescale 1ns/1ps
module adc_seq_chk #(
    parameter int unsigned UNIT_CYCLES = 2
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic adc_enable,
    input wire logic mod_sign,
    input wire logic [14:0] mod_magnitude,
    input wire adc_seq_pkg::front_end_t front_end,
    input wire logic [2:0] active_slot,
    input wire logic [15:0] current_result,
    input wire logic current_result_strobe
);
    import adc_seq_pkg::*;
    logic [31:0] conv_len;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // ========
    // Cycles spent converting
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_len <= 32'h0;
        end else if (front_end.convert) begin
            conv_len <= conv_len + 32'h1;
        end else begin
            conv_len <= 32'h0;
        end
    end
    a_conv_length: assert property (
        $fell(front_end.convert) && adc_enable && $past(adc_enable) |->
        conv_len >= (UNIT_CYCLES << (9 + $past(front_end.res_code))) &&
        conv_len <= (UNIT_CYCLES << (9 + $past(front_end.res_code))) + 1)
        else $error("conversion length wrong");
    a_abort_stops: assert property (
        $fell(adc_enable) |-> ##[0:3] !front_end.convert)
        else $error("convert after disable");
    a_slot_order: assert property (
        $changed(active_slot) |->
        active_slot == $past(active_slot) + 3'h1 || active_slot == 3'h0)
        else $error("slot visited out of order");
    a_short_only: assert property (
        front_end.input_short |-> front_end.source == SRC_OFFSET)
        else $error("short on other source");
    a_short_offset: assert property (
        front_end.convert && front_end.source == SRC_OFFSET |->
        front_end.input_short)
        else $error("offset source not shorted");
    a_strobe_pulse: assert property (
        current_result_strobe |=> !current_result_strobe)
        else $error("strobe too long");
    a_strobe_slot: assert property (
        current_result_strobe |->
        active_slot == 3'h0 || $past(active_slot) == 3'h0)
        else $error("strobe from other slot");
    a_result_cause: assert property (
        $changed(current_result) |->
        current_result_strobe || $past(current_result_strobe))
        else $error("result changed, no strobe");
    a_ctrl_held: assert property (
        front_end.convert && $past(front_end.convert) |->
        $stable(front_end.source) && $stable(front_end.res_code) &&
        $stable(front_end.ref_span))
        else $error("control changed");
endmodule
bind adc_conversion_sequencer adc_seq_chk #(.UNIT_CYCLES(UNIT_CYCLES)) chk (
    .core_clk, .reset_n, .scl_in, .sda_in, .sda_out, .sda_oe, .adc_enable,
    .mod_sign, .mod_magnitude, .front_end, .active_slot, .current_result,
    .current_result_strobe
);

// ===== sim/front_end_model.sv
// Behavioural analog mux and modulator front end.
// Assumes front_end comes straight from the sequencer.
`timescale 1ns/1ps
module front_end_model (
    input wire logic core_clk,
    input wire adc_seq_pkg::front_end_t front_end,
    output logic mod_sign,
    output logic [14:0] mod_magnitude
);
    import adc_seq_pkg::*;
    logic [15:0] word = 16'h0000;
    logic [15:0] next_word;
    logic [1:0] hold = 2'h0;
    // Shorted input reads zero, others a source-keyed pattern
    always_comb begin
        if (front_end.input_short) begin
            next_word = 16'h0000;
        end else begin
            next_word = {front_end.source[0],
                15'h5a5a ^ {11'h000, front_end.ref_span, front_end.source}};
        end
    end
    always_ff @(posedge core_clk) begin
        if (front_end.convert) begin
            word <= next_word;
            hold <= 2'h3;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end
    end
    // Result live during convert, held briefly after convert falls, inverted otherwise
    assign {mod_sign, mod_magnitude} = front_end.convert ? next_word :
        (hold != 2'h0 ? word : ~word);
endmodule

// ===== sim/adc_conversion_sequencer_test.sv
// Self-checking bench for the conversion sequencer.
// Assumes adc_seq_params.svh on the include path.
`timescale 1ns/1ps
`include "adc_seq_params.svh"
`define check(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    fail_count++; $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end end
module adc_conversion_sequencer_test;
    import adc_seq_pkg::*;
    logic core_clk, reset_n, scl, sda_drv, sda_line, adc_enable;
    logic sda_out, sda_oe, mod_sign, current_result_strobe, conv_q;
    logic [14:0] mod_magnitude;
    front_end_t front_end;
    logic [2:0] active_slot;
    logic [15:0] current_result, last_cur, r;
    logic [7:0] d, c;
    int fail_count, compares, strobe_seen, conv_rises, n;
    assign sda_line = (sda_oe ? sda_out : 1'b1) & sda_drv;
    adc_conversion_sequencer #(.UNIT_CYCLES(1)) uut (
        .core_clk, .reset_n, .scl_in(scl), .sda_in(sda_line), .sda_out,
        .sda_oe, .adc_enable, .mod_sign, .mod_magnitude, .front_end,
        .active_slot, .current_result, .current_result_strobe);
    front_end_model fe (.core_clk, .front_end, .mod_sign, .mod_magnitude);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        conv_q <= front_end.convert;
        if (front_end.convert && !conv_q) conv_rises <= conv_rises + 1;
        if (current_result_strobe) begin
            last_cur <= current_result;
            strobe_seen <= strobe_seen + 1;
        end
    end
    function automatic logic [15:0] expect_word(input logic [7:0] k);
        logic [14:0] mask;
        mask = (15'h1 << (8 + k[6:4])) - 15'h1;
        if (k[2:0] == 3'b110) return 16'h0000;
        return {k[0], (15'h5a5a ^ {11'h000, k[3], k[2:0]}) & mask};
    endfunction
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    task automatic line(input logic cl, input logic da);
        scl <= cl;
        sda_drv <= da;
        tick(3);
    endtask
    // ========
    // Two-wire bit: start, stop or data depending on a and b
    task automatic clk_bit(input logic a, input logic b, output logic i);
        line(1'b0, sda_drv);
        line(1'b0, a);
        line(1'b1, a);
        line(1'b1, b);
        @(negedge core_clk);
        i = sda_line;
        tick(1);
    endtask
    task automatic send_byte(input logic [7:0] b);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], b[i], a);
        end
        clk_bit(1'b1, 1'b1, a);
        `check("ack", 1'b0, a)
    endtask
    task automatic xfer(input logic [7:0] p, input logic rd,
        input logic [7:0] wv, output logic [7:0] v);
        logic a;
        clk_bit(1'b1, 1'b0, a);
        send_byte({`DEVICE_ADDR, 1'b0});
        send_byte(p);
        if (rd) begin
            clk_bit(1'b1, 1'b0, a);
            send_byte({`DEVICE_ADDR, 1'b1});
            for (int i = 7; i >= 0; i--) begin
                clk_bit(1'b1, 1'b1, a);
                v[i] = a;
            end
            clk_bit(1'b1, 1'b1, a);
        end else begin
            send_byte(wv);
        end
        clk_bit(1'b0, 1'b1, a);
    endtask
    task automatic read_result(input logic [2:0] s, output logic [15:0] v);
        xfer(`RESULT_BASE + {4'h0, s, 1'b0}, 1'b1, 8'h00, v[7:0]);
        xfer(`RESULT_BASE + {4'h0, s, 1'b1}, 1'b1, 8'h00, v[15:8]);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        tick(95000);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        reset_n = 1'b0;
        scl = 1'b1;
        sda_drv = 1'b1;
        adc_enable = 1'b0;
        tick(20);
        reset_n <= 1'b1;
        tick(2);
        // ========
        // Reset values, unmapped and read-only places
        xfer(`CTRL_BASE, 1'b1, 8'h00, d);
        `check("ctrl0 reset", `CTRL_RESET, d)
        read_result(3'h0, r);
        `check("result0 reset", `RESULT_RESET, r)
        xfer(8'h08, 1'b1, 8'h00, d);
        `check("unmapped", 8'h00, d)
        xfer(`RESULT_BASE, 1'b0, 8'hff, d);
        xfer(`RESULT_BASE, 1'b1, 8'h00, d);
        `check("result ro", 8'h00, d)
        $display("TEST registers done");
        // ========
        // Cycle over slots 0, 3 and 6
        xfer(8'h00, 1'b0, 8'h80, d);
        xfer(8'h03, 1'b0, 8'h9b, d);
        xfer(8'h06, 1'b0, 8'h8e, d);
        xfer(8'h07, 1'b0, 8'h7f, d);
        xfer(8'h07, 1'b1, 8'h00, d);
        `check("ctrl7 rw", 8'h7f, d)
        adc_enable <= 1'b1;
        n = 0;
        while (strobe_seen == 0 && n < 2000) begin
            tick(1);
            n++;
        end
        `check("current", expect_word(8'h80), last_cur)
        tick(2000);
        read_result(3'h0, r);
        `check("slot0", expect_word(8'h80), r)
        read_result(3'h1, r);
        `check("slot1 skipped", 16'h0000, r)
        read_result(3'h3, r);
        `check("slot3", expect_word(8'h9b), r)
        read_result(3'h6, r);
        `check("slot6", 16'h0000, r)
        `check("wrap", 1'b1, strobe_seen > 1)
        $display("TEST cycle done");
        // ========
        // Every mux source through the spare slot
        xfer(8'h00, 1'b0, 8'h00, d);
        xfer(8'h03, 1'b0, 8'h00, d);
        xfer(8'h06, 1'b0, 8'h00, d);
        for (int s = 0; s < 8; s++) begin
            c = {1'b1, 2'b00, s[1], s[0], s[2:0]};
            xfer(8'h07, 1'b0, c, d);
            tick(2200);
            read_result(3'h7, r);
            `check("spare", expect_word(c), r)
        end
        $display("TEST sources done");
        // ========
        // Abort mid conversion, then all slots disabled
        n = 0;
        while (!conv_q && n < 3000) begin
            tick(1);
            n++;
        end
        adc_enable <= 1'b0;
        tick(5);
        `check("abort", 1'b0, conv_q)
        xfer(8'h07, 1'b0, 8'h00, d);
        n = conv_rises;
        adc_enable <= 1'b1;
        tick(1500);
        `check("idle", n, conv_rises)
        $display("TEST abort and idle done");
        tally_and_finish();
    end
endmodule
